// *** rtl/pcb_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - bits 1:0 pick the pad output function, reset zero.
// - bits 4:3 route control: 0 local fields, 1 other logic, 2 fabric.
// - bit 5 active-low output enable, resets to one (driver off).
// - bits 7:6 idle state; pads 8 and 9 reset pull-down, others high-z.
// - bits 9:8 drive strength 2/4/8/12 mA, reset 4 mA.
// - bit 10 slew: one fast, zero slow; reset zero.
// - bit 11 receiver enable; resets one on pads 8 and 9, else zero.
// - bit 12 hysteresis enable, resets zero on every pad.
// - function code two hands pad control to the sensor-processing engine.
module pcb_bank #(
   parameter int ENGINE_PADS = 6'h3f
) (
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_n,
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [31:0] o_rdata,
   output logic      [11:0] o_pad_function_selector,
   output logic      [11:0] o_pad_ctl_source,
   output logic      [5:0]  o_pad_output_enable_low,
   output logic      [11:0] o_pad_idle_state,
   output logic      [11:0] o_pad_drive,
   output logic      [5:0]  o_pad_slew_select,
   output logic      [5:0]  o_pad_recv_enable,
   output logic      [5:0]  o_pad_hysteresis_enable
);
   localparam int N = pcb_pkg::NUM_PADS;

   typedef struct packed {
      logic [31:0]  rdata;
      logic [11:0]  func;
      logic [11:0]  ctl;
      logic [5:0]   oen_n;
      logic [11:0]  idle;
      logic [11:0]  drive;
      logic [5:0]   slew;
      logic [5:0]   recv;
      logic [5:0]   hyst;
   } pcb_state_type;

   pcb_state_type st;
   pcb_state_type next_st;

   logic [N-1:0]  wr_sel;
   logic [12:0]   cfg [N];
   logic [1:0]    ctl [N];

   ////////////////////////////////////////////////////////////////////////////
   // address decode
   function automatic logic [N-1:0] pcb_decode(input logic [7:0] addr);
      logic [N-1:0] hit;
      hit = '0;
      case (addr)
         pcb_pkg::OFF_PAD7:  hit[0] = 1'b1;
         pcb_pkg::OFF_PAD8:  hit[1] = 1'b1;
         pcb_pkg::OFF_PAD9:  hit[2] = 1'b1;
         pcb_pkg::OFF_PAD10: hit[3] = 1'b1;
         pcb_pkg::OFF_PAD11: hit[4] = 1'b1;
         pcb_pkg::OFF_PAD12: hit[5] = 1'b1;
         default:            hit    = '0;
      endcase
      return hit;
   endfunction : pcb_decode

   assign wr_sel = i_wr ? pcb_decode(i_addr) : '0;

   ////////////////////////////////////////////////////////////////////////////
   // pad registers and control routing
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_pad
         localparam bit PULLED = (g == 1) || (g == 2);
         pcb_cfg_reg #(
            .RESET_VALUE(PULLED ? pcb_pkg::RESET_PULLED : pcb_pkg::RESET_PLAIN)
         ) u_reg (
            .i_ref_clk (i_ref_clk),
            .i_rst_n   (i_rst_n),
            .i_wr      (wr_sel[g]),
            .i_wdata   (i_wdata[12:0]),
            .o_cfg     (cfg[g])
         );
         pcb_route #(
            .HAS_ENGINE(ENGINE_PADS[g])
         ) u_route (
            .i_cfg (cfg[g]),
            .o_ctl (ctl[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // output staging and read data
   always_comb begin
      logic [N-1:0] rd_hit;
      rd_hit  = pcb_decode(i_addr);
      next_st = st;
      next_st.rdata = '0;
      if (i_rd) begin
         for (int k = 0; k < N; k++) begin
            if (rd_hit[k]) begin
               next_st.rdata = {19'h0, cfg[k]};
            end
         end
      end
      for (int k = 0; k < N; k++) begin
         next_st.func[2*k +: 2]  = cfg[k][pcb_pkg::FUNC_LO +: 2];
         next_st.ctl[2*k +: 2]   = ctl[k];
         next_st.oen_n[k]        = cfg[k][pcb_pkg::OEN_BIT];
         next_st.idle[2*k +: 2]  = cfg[k][pcb_pkg::IDLE_LO +: 2];
         next_st.drive[2*k +: 2] = cfg[k][pcb_pkg::DRIVE_LO +: 2];
         next_st.slew[k]         = cfg[k][pcb_pkg::SLEW_BIT];
         next_st.recv[k]         = cfg[k][pcb_pkg::RECV_BIT];
         next_st.hyst[k]         = cfg[k][pcb_pkg::HYST_BIT];
      end
      if (!i_rst_n) begin
         next_st       = '0;
         next_st.oen_n = '1;
         for (int k = 0; k < N; k++) begin
            next_st.drive[2*k +: 2] = pcb_pkg::DRIVE_4MA;
         end
         next_st.idle[3:2] = pcb_pkg::IDLE_PULLDN;
         next_st.idle[5:4] = pcb_pkg::IDLE_PULLDN;
         next_st.recv[2:1] = 2'h3;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      st <= next_st;
   end

   assign o_rdata                 = st.rdata;
   assign o_pad_function_selector = st.func;
   assign o_pad_ctl_source        = st.ctl;
   assign o_pad_output_enable_low = st.oen_n;
   assign o_pad_idle_state        = st.idle;
   assign o_pad_drive             = st.drive;
   assign o_pad_slew_select       = st.slew;
   assign o_pad_recv_enable       = st.recv;
   assign o_pad_hysteresis_enable = st.hyst;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_oen_reset: assert property (@(posedge i_ref_clk) !i_rst_n |=> o_pad_output_enable_low == 6'h3f)
      else $error("output enables not off after reset");
   a_idle_reset: assert property (@(posedge i_ref_clk) !i_rst_n |=> o_pad_idle_state == 12'h028)
      else $error("idle state reset wrong");
   a_drive_reset: assert property (@(posedge i_ref_clk) !i_rst_n |=> o_pad_drive == 12'h555)
      else $error("drive reset not 4 mA");
   a_recv_reset: assert property (@(posedge i_ref_clk) !i_rst_n |=> o_pad_recv_enable == 6'h06)
      else $error("receiver reset wrong");
   a_hyst_reset: assert property (@(posedge i_ref_clk) !i_rst_n |=> o_pad_hysteresis_enable == 6'h00)
      else $error("hysteresis reset wrong");
   a_func_write: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_wr && i_addr == pcb_pkg::OFF_PAD10 ##1 i_rst_n [*1] |=> o_pad_function_selector[7:6] == $past(i_wdata[1:0], 2))
      else $error("function selector not updated");
   a_slew_write: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_wr && i_addr == pcb_pkg::OFF_PAD8 |=> ##1 o_pad_slew_select[1] == $past(i_wdata[10], 2))
      else $error("slew not updated");
   a_read_mask: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_rd |=> o_rdata[31:13] == 19'h0 && o_rdata[2] == 1'b0)
      else $error("reserved bits read nonzero");
   a_src_route: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      cfg[3][1:0] != pcb_pkg::FUNC_ENGINE && cfg[3][4:3] == pcb_pkg::SRC_FABRIC
      |=> o_pad_ctl_source[7:6] == pcb_pkg::CTL_FABRIC)
      else $error("control source not fabric");
   a_engine_route: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      cfg[4][1:0] == pcb_pkg::FUNC_ENGINE |=> o_pad_ctl_source[9:8] == pcb_pkg::CTL_ENGINE)
      else $error("engine takeover missing");
   c_read: cover property (@(posedge i_ref_clk) i_rd && i_addr == pcb_pkg::OFF_PAD9);
   c_enable: cover property (@(posedge i_ref_clk) $fell(o_pad_output_enable_low[3]));
   c_engine: cover property (@(posedge i_ref_clk) o_pad_ctl_source[9:8] == pcb_pkg::CTL_ENGINE);
endmodule : pcb_bank
`default_nettype wire

// *** inc/pcb_pkg.sv ***
package pcb_pkg;
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 32;
   localparam int          NUM_PADS        = 6;
   localparam int          FIRST_PAD       = 7;
   localparam int          CFG_W           = 13;
   // byte offsets of the pad registers
   localparam logic [7:0]  OFF_PAD7        = 8'h1c;
   localparam logic [7:0]  OFF_PAD8        = 8'h20;
   localparam logic [7:0]  OFF_PAD9        = 8'h24;
   localparam logic [7:0]  OFF_PAD10       = 8'h28;
   localparam logic [7:0]  OFF_PAD11       = 8'h2c;
   localparam logic [7:0]  OFF_PAD12       = 8'h30;
   // field positions
   localparam int          FUNC_LO         = 0;
   localparam int          SRC_LO          = 3;
   localparam int          OEN_BIT         = 5;
   localparam int          IDLE_LO         = 6;
   localparam int          DRIVE_LO        = 8;
   localparam int          SLEW_BIT        = 10;
   localparam int          RECV_BIT        = 11;
   localparam int          HYST_BIT        = 12;
   // writable bits: 1:0 and 12:3, bit 2 reserved
   localparam logic [12:0] WRITE_MASK      = 13'h1ffb;
   // field codes
   localparam logic [1:0]  SRC_LOCAL       = 2'h0;
   localparam logic [1:0]  SRC_OTHER       = 2'h1;
   localparam logic [1:0]  SRC_FABRIC      = 2'h2;
   localparam logic [1:0]  FUNC_ENGINE     = 2'h2;
   localparam logic [1:0]  IDLE_HIZ        = 2'h0;
   localparam logic [1:0]  IDLE_PULLDN     = 2'h2;
   localparam logic [1:0]  DRIVE_4MA       = 2'h1;
   // reset values: func 0, src 0, oen 1, drive 4 mA
   localparam logic [12:0] RESET_PLAIN     = 13'h0120;
   localparam logic [12:0] RESET_PULLED    = 13'h09a0;
   // pad-control source index on the output bus
   localparam logic [1:0]  CTL_LOCAL       = 2'h0;
   localparam logic [1:0]  CTL_OTHER       = 2'h1;
   localparam logic [1:0]  CTL_FABRIC      = 2'h2;
   localparam logic [1:0]  CTL_ENGINE      = 2'h3;
endpackage : pcb_pkg

// *** rtl/pcb_cfg_reg.sv ***
`timescale 1ns/1ps
`default_nettype none
module pcb_cfg_reg #(
   parameter logic [12:0] RESET_VALUE = pcb_pkg::RESET_PLAIN
) (
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_wr,
   input  wire logic [12:0] i_wdata,
   output logic      [12:0] o_cfg
);
   typedef struct packed {
      logic [12:0] cfg;
   } pcb_reg_state_type;

   pcb_reg_state_type st;
   pcb_reg_state_type next_st;

   always_comb begin
      next_st = st;
      if (!i_rst_n) begin
         next_st.cfg = RESET_VALUE;
      end else if (i_wr) begin
         next_st.cfg = i_wdata & pcb_pkg::WRITE_MASK;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      st <= next_st;
   end

   assign o_cfg = st.cfg;
endmodule : pcb_cfg_reg
`default_nettype wire

// *** rtl/pcb_route.sv ***
`timescale 1ns/1ps
`default_nettype none
module pcb_route #(
   parameter bit HAS_ENGINE = 1'b1
) (
   input  wire logic [12:0] i_cfg,
   output logic      [1:0]  o_ctl
);
   logic [1:0] src;
   logic [1:0] func;

   always_comb begin
      src  = i_cfg[pcb_pkg::SRC_LO +: 2];
      func = i_cfg[pcb_pkg::FUNC_LO +: 2];
      if (HAS_ENGINE && func == pcb_pkg::FUNC_ENGINE) begin
         o_ctl = pcb_pkg::CTL_ENGINE;
      end else begin
         case (src)
            pcb_pkg::SRC_OTHER:  o_ctl = pcb_pkg::CTL_OTHER;
            pcb_pkg::SRC_FABRIC: o_ctl = pcb_pkg::CTL_FABRIC;
            default:             o_ctl = pcb_pkg::CTL_LOCAL;
         endcase
      end
   end
endmodule : pcb_route
`default_nettype wire

// *** verif/pad_control_bank_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module pad_control_bank_tb;
   logic        i_ref_clk;
   logic        i_rst_n;
   logic [7:0]  i_addr;
   logic [31:0] i_wdata;
   logic        i_wr;
   logic        i_rd;
   logic [31:0] o_rdata;
   logic [11:0] fn;
   logic [11:0] ctl;
   logic [5:0]  oen;
   logic [11:0] idle;
   logic [11:0] drv;
   logic [5:0]  slew;
   logic [5:0]  recv;
   logic [5:0]  hyst;
   int          errors;
   int          comparisons;
   int          cycles;
   ////////////////////////////////////////////////////////////////////////////////
   pcb_bank dut_u (
      .i_ref_clk               (i_ref_clk),
      .i_rst_n                 (i_rst_n),
      .i_addr                  (i_addr),
      .i_wdata                 (i_wdata),
      .i_wr                    (i_wr),
      .i_rd                    (i_rd),
      .o_rdata                 (o_rdata),
      .o_pad_function_selector (fn),
      .o_pad_ctl_source        (ctl),
      .o_pad_output_enable_low (oen),
      .o_pad_idle_state        (idle),
      .o_pad_drive             (drv),
      .o_pad_slew_select       (slew),
      .o_pad_recv_enable       (recv),
      .o_pad_hysteresis_enable (hyst)
   );
   ////////////////////////////////////////////////////////////////////////////////
   always #25 i_ref_clk = ~i_ref_clk;
   always @(posedge i_ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         errors <= errors + 1;
         complete_run();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] pa(input int k);
      return pcb_pkg::OFF_PAD7 + 8'(4 * k);
   endfunction : pa
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_ref_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_ref_clk);
      i_wr    <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge i_ref_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_ref_clk);
      i_rd   <= 1'b0;
      #1;
      chk(o_rdata, exp);
      @(posedge i_ref_clk);
      #1;
      chk(o_rdata, 32'h0);
   endtask : rd
   task automatic pads(input int k, input logic [12:0] c);
      logic [1:0] s;
      s = (c[1:0] == 2'h2) ? 2'h3 : ((c[4:3] == 2'h3) ? 2'h0 : c[4:3]);
      chk(32'(fn[2*k +: 2]), 32'(c[1:0]));
      chk(32'(ctl[2*k +: 2]), 32'(s));
      chk(32'(oen[k]), 32'(c[5]));
      chk(32'(idle[2*k +: 2]), 32'(c[7:6]));
      chk(32'(drv[2*k +: 2]), 32'(c[9:8]));
      chk(32'(slew[k]), 32'(c[10]));
      chk(32'(recv[k]), 32'(c[11]));
      chk(32'(hyst[k]), 32'(c[12]));
   endtask : pads
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [12:0] e;
      for (int k = 0; k < 6; k++) begin
         e = (k == 1 || k == 2) ? 13'h09a0 : 13'h0120;
         rd(pa(k), 32'(e));
         pads(k, e);
      end
      $display("test reset values done");
   endtask : t_reset
   task automatic t_fields();
      logic [31:0] w [3];
      w = '{32'hffffffff, 32'hfffff555, 32'h00000000};
      for (int i = 0; i < 3; i++) begin
         wr(pa(3), w[i]);
         rd(pa(3), w[i] & 32'h00001ffb);
         pads(3, w[i][12:0] & 13'h1ffb);
         wr(pa(1), w[i]);
         rd(pa(1), w[i] & 32'h00001ffb);
         pads(1, w[i][12:0] & 13'h1ffb);
      end
      $display("test field write and read done");
   endtask : t_fields
   task automatic t_source();
      logic [12:0] v;
      for (int f = 0; f < 4; f++) begin
         for (int s = 0; s < 4; s++) begin
            v = {8'h00, 2'(s), 1'b0, 2'(f)};
            wr(pa(4), 32'(v));
            rd(pa(4), 32'(v));
            pads(4, v);
         end
      end
      $display("test control source done");
   endtask : t_source
   task automatic t_unmapped();
      wr(8'h34, 32'hffffffff);
      wr(8'h18, 32'hffffffff);
      rd(8'h34, 32'h0);
      rd(8'h18, 32'h0);
      rd(pa(5), 32'h120);
      pads(5, 13'h0120);
      rd(pa(0), 32'h120);
      $display("test unmapped access done");
   endtask : t_unmapped
   task automatic complete_run();
      $display("comparisons=%0d errors=%0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : complete_run
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      i_ref_clk   = 1'b0;
      i_rst_n     = 1'b0;
      i_addr      = 8'h00;
      i_wdata     = 32'h0;
      i_wr        = 1'b0;
      i_rd        = 1'b0;
      errors      = 0;
      comparisons = 0;
      cycles      = 0;
      repeat (10) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      t_reset();
      t_fields();
      t_source();
      t_unmapped();
      complete_run();
   end
endmodule : pad_control_bank_tb
`default_nettype wire
